// ---- dsfp_cfg.svh ----
// Constants of the dual-slope PWM timer: offsets, fields, resets, codes.
// Assumes inclusion by bare name from the prescaler, the timer and the testbench.
`ifndef DSFP_CFG_SVH
`define DSFP_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DSFP_OFS_WAVE_CTRL 8'h00
`define DSFP_OFS_CTRL_B 8'h04
`define DSFP_OFS_COUNT 8'h08
`define DSFP_OFS_CMP_A 8'h0C
`define DSFP_OFS_CMP_B 8'h10
`define DSFP_OFS_CAP_TOP 8'h14
`define DSFP_OFS_FLAGS 8'h18
`define DSFP_OFS_PIN_DIR 8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSFP_WC_ACT_A_HI 7
`define DSFP_WC_ACT_A_LO 6
`define DSFP_WC_ACT_B_HI 5
`define DSFP_WC_ACT_B_LO 4
`define DSFP_WC_FORCE_A 3
`define DSFP_WC_FORCE_B 2
`define DSFP_CB_WGM_HI 4
`define DSFP_CB_WGM_LO 3
`define DSFP_CB_CS_HI 2
`define DSFP_FL_OVF 0
`define DSFP_FL_CMP_A 1
`define DSFP_FL_CMP_B 2
`define DSFP_FL_CAP 3

// ----------------------------------------
// Reset values and counter limits
// ----------------------------------------
`define DSFP_RST_WAVE_CTRL 8'h00
`define DSFP_RST_CTRL_B 8'h00
`define DSFP_RST_WORD 16'h0000
`define DSFP_TOP_MIN 16'h0003
`define DSFP_TOP_MAX 16'hFFFF

// ----------------------------------------
// Waveform select and output action codes
// ----------------------------------------
`define DSFP_WGM_PFC_CAP 4'h8
`define DSFP_WGM_PFC_CMPA 4'h9
`define DSFP_WGM_CTC_CMPA 4'h4
`define DSFP_WGM_CTC_CAP 4'hC
`define DSFP_ACT_OFF 2'h0
`define DSFP_ACT_TOGGLE 2'h1
`define DSFP_ACT_LOW 2'h2
`define DSFP_ACT_HIGH 2'h3

// ----------------------------------------
// Prescaler divide masks (divisor minus one)
// ----------------------------------------
`define DSFP_DIV1_MASK 10'h000
`define DSFP_DIV8_MASK 10'h007
`define DSFP_DIV16_MASK 10'h00F
`define DSFP_DIV32_MASK 10'h01F
`define DSFP_DIV64_MASK 10'h03F
`define DSFP_DIV256_MASK 10'h0FF
`define DSFP_DIV1024_MASK 10'h3FF

`endif

// ---- dsfp_pkg.sv ----
// Types shared by the dual-slope PWM timer modules.
// Assumes dsfp_cfg.svh is on the include path.
package dsfp_pkg;
  // Counting direction of the dual-slope counter
  typedef enum logic {DSFP_UP, DSFP_DOWN} dsfp_dir_t;
  // Four-bit waveform select
  typedef logic [3:0] dsfp_wgm_t;
  // Output action field
  typedef logic [1:0] dsfp_act_t;
endpackage

// ---- dsfp_prescaler.sv ----
// Timer tick generator: divides the I/O clock by a selectable factor.
// Assumes one clock, synchronous active-high reset, clock enable freeze.
`timescale 1ns/1ps
`default_nettype none
`include "dsfp_cfg.svh"

module dsfp_prescaler
  import dsfp_pkg::*;
#(
  parameter bit THIRD_TIMER = 1'b0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] clk_sel_i,
  output logic tick_o
);

  logic [9:0] div_q;
  logic [9:0] mask_w;
  logic run_w;

  // Select 0 stops, 1..5 divide by 1/8/64/256/1024, 6..7 by 16/32 on the third timer, else stop
  function automatic logic [9:0] div_mask(input logic [2:0] sel, input logic third);
    case (sel)
      3'h1: div_mask = `DSFP_DIV1_MASK;
      3'h2: div_mask = `DSFP_DIV8_MASK;
      3'h3: div_mask = `DSFP_DIV64_MASK;
      3'h4: div_mask = `DSFP_DIV256_MASK;
      3'h5: div_mask = `DSFP_DIV1024_MASK;
      3'h6: div_mask = third ? `DSFP_DIV16_MASK : `DSFP_DIV1_MASK;
      3'h7: div_mask = third ? `DSFP_DIV32_MASK : `DSFP_DIV1_MASK;
      default: div_mask = `DSFP_DIV1_MASK;
    endcase
  endfunction

  assign mask_w = div_mask(clk_sel_i, THIRD_TIMER);
  assign run_w = (clk_sel_i != 3'h0) && (THIRD_TIMER || clk_sel_i < 3'h6);

  // Free-running divider, cleared while stopped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_q <= 10'h000;
    else if (ce_i)
      div_q <= run_w ? div_q + 10'h001 : 10'h000;
  end

  // Tick when the selected low bits are all ones
  assign tick_o = run_w && ((div_q & mask_w) == mask_w); // RULE15

endmodule
`default_nettype wire

// ---- dsfp_pwm.sv ----
// 16-bit dual-slope, frequency-correct PWM timer with Wishbone registers.
// Assumes a classic Wishbone master on clk_i and pins buffered outside.
//
// Functional notes
// RULE1: Mode 8 takes TOP from capture register, mode 9 from channel A compare.
// RULE2: TOP accepted from 0x0003 up to 0xFFFF.
// RULE3: Count up to TOP, hold TOP one tick, then count down.
// RULE4: Counter equal to compare value sets that channel's flag.
// RULE5: Active compare values load from buffers at BOTTOM.
// RULE6: Overflow flag sets in the tick the buffers load at BOTTOM.
// RULE7: TOP source flag (channel A or capture) sets when counter reaches TOP.
// RULE8: Software keeps TOP at or above every compare value.
// RULE9: Software should use channel A as TOP for run-time frequency changes.
// RULE10: Action 2 gives non-inverted PWM, action 3 inverted.
// RULE11: Non-inverted clears on up-count match, sets on down-count match.
// RULE12: Compare output reaches the pin only with its direction bit set.
// RULE13: Compare at BOTTOM gives constant low, at TOP high, non-inverted.
// RULE14: Mode 9 with channel A action 1 toggles A at each match.
// RULE15: Tick divides clock by 1, 8, 64, 256, 1024; third timer adds 16, 32.
// RULE16: Fully synchronous; tick is only a clock enable.
// RULE17: Control A holds actions 7:6, 5:4, force bits 3:2, low select 1:0.
// RULE18: Nonzero action overrides port function; driver still needs direction.
// RULE19: Non-PWM actions: off, toggle, low, high on match.
// RULE20: Low select bits join high bits in control B for four-bit mode.
// RULE21: At BOTTOM the counter reverses up and repeats continuously.
`timescale 1ns/1ps
`default_nettype none
`include "dsfp_cfg.svh"

module dsfp_pwm
  import dsfp_pkg::*;
#(
  parameter bit THIRD_TIMER = 1'b0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wave_out_a_o,
  output logic wave_oe_a_o,
  output logic wave_ovr_a_o,
  output logic wave_out_b_o,
  output logic wave_oe_b_o,
  output logic wave_ovr_b_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  dsfp_act_t act_a_q, act_b_q;
  logic [1:0] wgm_lo_q, wgm_hi_q;
  logic [2:0] clk_sel_q;
  logic [15:0] count_value_q, cmp_a_buf_q, cmp_b_buf_q, cmp_a_q, cmp_b_q;
  logic [15:0] capture_top_value_q;
  logic [3:0] flags_q, flag_set_w, flag_clr_w;
  logic [1:0] pin_dir_q;
  dsfp_dir_t dir_q;
  dsfp_wgm_t wgm_w;
  logic [15:0] top_raw_w, top_w;
  logic [31:0] rd_w;
  // Reset words of the control registers, sliced into their fields
  localparam logic [7:0] RST_WC = `DSFP_RST_WAVE_CTRL;
  localparam logic [7:0] RST_CB = `DSFP_RST_CTRL_B;
  logic req_w, wr_w, tick_w, tick_en_w, tick_go_w, cnt_wr_w;
  logic dual_w, ctc_w, bottom_w, at_top_w, up_w, hit_a_w, hit_b_w;
  logic force_a_w, force_b_w;

  // Merge write data into a 16-bit register by byte lanes 0 and 1
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
                                              input logic [1:0] sel);
    lane_merge = old;
    for (int i = 0; i < 2; i++)
    begin
      if (sel[i])
        lane_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // Next compare output level for one channel
  function automatic logic oc_next(input logic oc, input dsfp_act_t act, input logic dual,
                                   input logic up, input logic hit, input logic at_lo,
                                   input logic at_hi, input logic tog_ok);
    oc_next = oc;
    if (dual)
    begin
      if (act[1])
      begin
        if (at_lo)
          oc_next = act[0]; // RULE13
        else if (at_hi)
          oc_next = !act[0]; // RULE13
        else if (hit)
          oc_next = up ? act[0] : !act[0]; // RULE10 RULE11
      end
      else if (act == `DSFP_ACT_TOGGLE && tog_ok && hit)
        oc_next = !oc; // RULE14
    end
    else if (hit)
    begin
      case (act)
        `DSFP_ACT_TOGGLE: oc_next = !oc; // RULE19
        `DSFP_ACT_LOW: oc_next = 1'b0; // RULE19
        `DSFP_ACT_HIGH: oc_next = 1'b1; // RULE19
        default: oc_next = oc;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_w = req_w && wb_we_i;

  // Registered acknowledge, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else if (ce_i)
      wb_ack_o <= req_w;
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb
  begin
    rd_w = 32'h0000_0000;
    case (wb_adr_i)
      `DSFP_OFS_WAVE_CTRL: rd_w[7:0] = {act_a_q, act_b_q, 2'b00, wgm_lo_q}; // RULE17
      `DSFP_OFS_CTRL_B: rd_w[4:0] = {wgm_hi_q, clk_sel_q};
      `DSFP_OFS_COUNT: rd_w[15:0] = count_value_q;
      `DSFP_OFS_CMP_A: rd_w[15:0] = cmp_a_buf_q;
      `DSFP_OFS_CMP_B: rd_w[15:0] = cmp_b_buf_q;
      `DSFP_OFS_CAP_TOP: rd_w[15:0] = capture_top_value_q;
      `DSFP_OFS_FLAGS: rd_w[3:0] = flags_q;
      `DSFP_OFS_PIN_DIR: rd_w[1:0] = pin_dir_q;
      default: rd_w = 32'h0000_0000;
    endcase
  end

  // Read data captured with the acknowledge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (ce_i && req_w)
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_w;
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {act_a_q, act_b_q, wgm_lo_q} <= {RST_WC[7:4], RST_WC[1:0]};
      {wgm_hi_q, clk_sel_q} <= RST_CB[4:0];
      pin_dir_q <= 2'b00;
    end
    else if (ce_i && wr_w && wb_sel_i[0])
    begin
      case (wb_adr_i)
        `DSFP_OFS_WAVE_CTRL:
        begin
          act_a_q <= wb_dat_i[`DSFP_WC_ACT_A_HI:`DSFP_WC_ACT_A_LO]; // RULE17
          act_b_q <= wb_dat_i[`DSFP_WC_ACT_B_HI:`DSFP_WC_ACT_B_LO]; // RULE17
          wgm_lo_q <= wb_dat_i[1:0]; // RULE17
        end
        `DSFP_OFS_CTRL_B:
        begin
          wgm_hi_q <= wb_dat_i[`DSFP_CB_WGM_HI:`DSFP_CB_WGM_LO];
          clk_sel_q <= wb_dat_i[`DSFP_CB_CS_HI:0];
        end
        `DSFP_OFS_PIN_DIR: pin_dir_q <= wb_dat_i[1:0];
        default: pin_dir_q <= pin_dir_q;
      endcase
    end
  end

  // Force strobes act only outside the dual-slope modes and never store
  assign force_a_w = wr_w && wb_sel_i[0] && wb_adr_i == `DSFP_OFS_WAVE_CTRL
                     && wb_dat_i[`DSFP_WC_FORCE_A] && !dual_w;
  assign force_b_w = wr_w && wb_sel_i[0] && wb_adr_i == `DSFP_OFS_WAVE_CTRL
                     && wb_dat_i[`DSFP_WC_FORCE_B] && !dual_w;

  // ----------------------------------------
  // Mode decode and TOP selection
  // ----------------------------------------
  assign wgm_w = {wgm_hi_q, wgm_lo_q}; // RULE20
  assign dual_w = wgm_w == `DSFP_WGM_PFC_CAP || wgm_w == `DSFP_WGM_PFC_CMPA;
  assign ctc_w = wgm_w == `DSFP_WGM_CTC_CMPA || wgm_w == `DSFP_WGM_CTC_CAP;

  always_comb
  begin
    case (wgm_w)
      `DSFP_WGM_PFC_CAP, `DSFP_WGM_CTC_CAP: top_raw_w = capture_top_value_q; // RULE1
      `DSFP_WGM_PFC_CMPA, `DSFP_WGM_CTC_CMPA: top_raw_w = cmp_a_q; // RULE1
      default: top_raw_w = `DSFP_TOP_MAX;
    endcase
  end

  // Dual-slope TOP never goes below the 2-bit minimum
  assign top_w = (dual_w && top_raw_w < `DSFP_TOP_MIN) ? `DSFP_TOP_MIN : top_raw_w; // RULE2

  // ----------------------------------------
  // Timer tick and counter
  // ----------------------------------------
  dsfp_prescaler #(
    .THIRD_TIMER(THIRD_TIMER)
  ) u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clk_sel_i(clk_sel_q),
    .tick_o(tick_w)
  );

  assign cnt_wr_w = wr_w && wb_adr_i == `DSFP_OFS_COUNT && (wb_sel_i[1:0] != 2'b00);
  assign tick_en_w = ce_i && tick_w; // RULE16
  assign tick_go_w = tick_en_w && !cnt_wr_w;
  assign up_w = dir_q == DSFP_UP;
  assign at_top_w = count_value_q == top_w;
  assign bottom_w = dual_w && tick_go_w && count_value_q == `DSFP_RST_WORD;

  // Dual slope: up to TOP, one tick at TOP, down to BOTTOM, and again; other modes count up
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_value_q <= `DSFP_RST_WORD;
      dir_q <= DSFP_UP;
    end
    else if (ce_i && cnt_wr_w)
      count_value_q <= lane_merge(count_value_q, wb_dat_i[15:0], wb_sel_i[1:0]);
    else if (tick_go_w)
    begin
      if (!dual_w)
      begin
        dir_q <= DSFP_UP;
        count_value_q <= (ctc_w && at_top_w) ? `DSFP_RST_WORD : count_value_q + 16'h0001;
      end
      else if (up_w)
      begin
        if (at_top_w)
        begin
          dir_q <= DSFP_DOWN; // RULE3
          count_value_q <= count_value_q - 16'h0001;
        end
        else
          count_value_q <= count_value_q + 16'h0001;
      end
      else if (count_value_q == `DSFP_RST_WORD)
      begin
        dir_q <= DSFP_UP; // RULE21
        count_value_q <= 16'h0001;
      end
      else
        count_value_q <= count_value_q - 16'h0001;
    end
  end

  // ----------------------------------------
  // Compare buffers and capture/top register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmp_a_buf_q <= `DSFP_RST_WORD;
      cmp_b_buf_q <= `DSFP_RST_WORD;
      capture_top_value_q <= `DSFP_RST_WORD;
    end
    else if (ce_i && wr_w)
    begin
      case (wb_adr_i)
        `DSFP_OFS_CMP_A: cmp_a_buf_q <= lane_merge(cmp_a_buf_q, wb_dat_i[15:0], wb_sel_i[1:0]);
        `DSFP_OFS_CMP_B: cmp_b_buf_q <= lane_merge(cmp_b_buf_q, wb_dat_i[15:0], wb_sel_i[1:0]);
        `DSFP_OFS_CAP_TOP:
          capture_top_value_q <= lane_merge(capture_top_value_q, wb_dat_i[15:0],
                                            wb_sel_i[1:0]);
        default: capture_top_value_q <= capture_top_value_q;
      endcase
    end
  end

  // Active compare values: at BOTTOM in dual slope, else the next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmp_a_q <= `DSFP_RST_WORD;
      cmp_b_q <= `DSFP_RST_WORD;
    end
    else if (ce_i && (!dual_w || bottom_w))
    begin
      cmp_a_q <= cmp_a_buf_q; // RULE5
      cmp_b_q <= cmp_b_buf_q; // RULE5
    end
  end

  // ----------------------------------------
  // Flags: hardware set wins over write-one clear
  // ----------------------------------------
  assign hit_a_w = tick_go_w && count_value_q == cmp_a_q;
  assign hit_b_w = tick_go_w && count_value_q == cmp_b_q;

  always_comb
  begin
    flag_set_w = 4'h0;
    flag_set_w[`DSFP_FL_OVF] = dual_w ? bottom_w
                               : (tick_go_w && count_value_q == `DSFP_TOP_MAX); // RULE6
    flag_set_w[`DSFP_FL_CMP_A] = hit_a_w
                                 || (tick_go_w && wgm_w == `DSFP_WGM_PFC_CMPA && at_top_w); // RULE4 RULE7
    flag_set_w[`DSFP_FL_CMP_B] = hit_b_w; // RULE4
    flag_set_w[`DSFP_FL_CAP] = tick_go_w && wgm_w == `DSFP_WGM_PFC_CAP && at_top_w; // RULE7
  end

  assign flag_clr_w = (wr_w && wb_sel_i[0] && wb_adr_i == `DSFP_OFS_FLAGS) ? wb_dat_i[3:0] : 4'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_q <= 4'h0;
    else if (ce_i)
      flags_q <= (flags_q & ~flag_clr_w) | flag_set_w;
  end

  // ----------------------------------------
  // Compare outputs and pin gating
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wave_out_a_o <= 1'b0;
      wave_out_b_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wave_out_a_o <= oc_next(wave_out_a_o, act_a_q, dual_w, up_w, hit_a_w || force_a_w,
                              cmp_a_q == `DSFP_RST_WORD, cmp_a_q == top_w,
                              wgm_w == `DSFP_WGM_PFC_CMPA);
      wave_out_b_o <= oc_next(wave_out_b_o, act_b_q, dual_w, up_w, hit_b_w || force_b_w,
                              cmp_b_q == `DSFP_RST_WORD, cmp_b_q == top_w, 1'b0);
    end
  end

  // Override on any nonzero action; driver also needs the direction bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {wave_ovr_a_o, wave_ovr_b_o, wave_oe_a_o, wave_oe_b_o} <= 4'h0;
    end
    else if (ce_i)
    begin
      wave_ovr_a_o <= act_a_q != `DSFP_ACT_OFF; // RULE18
      wave_ovr_b_o <= act_b_q != `DSFP_ACT_OFF; // RULE18
      wave_oe_a_o <= act_a_q != `DSFP_ACT_OFF && pin_dir_q[0]; // RULE12
      wave_oe_b_o <= act_b_q != `DSFP_ACT_OFF && pin_dir_q[1]; // RULE12
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_bottom;
    dual_w && tick_go_w && count_value_q == 16'h0000;
  endsequence

  a_mode_top_src: assert property (wgm_w == `DSFP_WGM_PFC_CAP
    |-> top_w == ((capture_top_value_q < 16'h0003) ? 16'h0003 : capture_top_value_q)) // RULE1
    else $error("mode 8 TOP not from capture register");
  a_top_floor: assert property (dual_w |-> top_w >= 16'h0003) // RULE2
    else $error("TOP below minimum");
  a_top_turn: assert property (dual_w && tick_go_w && up_w && at_top_w
    |=> dir_q == DSFP_DOWN && count_value_q == $past(count_value_q) - 16'h0001) // RULE3
    else $error("counter did not turn at TOP");
  a_cmp_b_flag: assert property (hit_b_w |=> flags_q[`DSFP_FL_CMP_B]) // RULE4
    else $error("compare B flag missed");
  a_bottom_load: assert property (s_bottom |=> cmp_a_q == $past(cmp_a_buf_q)
    && flags_q[`DSFP_FL_OVF]) // RULE5
    else $error("buffer load or overflow missing at BOTTOM");
  a_ovf_only_bottom: assert property (dual_w && ce_i && !bottom_w && !$past(flags_q[0])
    |=> !flags_q[`DSFP_FL_OVF] || $past(flags_q[`DSFP_FL_OVF])) // RULE6
    else $error("overflow flag set away from BOTTOM");
  a_cap_top_flag: assert property (wgm_w == `DSFP_WGM_PFC_CAP && tick_go_w && at_top_w
    |=> flags_q[`DSFP_FL_CAP]) // RULE7
    else $error("capture flag missed at TOP");
  a_pwm_clear_up: assert property (dual_w && act_a_q == 2'h2 && hit_a_w && up_w
    && cmp_a_q != 16'h0000 && cmp_a_q != top_w |=> !wave_out_a_o) // RULE11
    else $error("non-inverted output not cleared on up match");
  a_pin_gate: assert property ($past(ce_i) && wave_oe_b_o
    |-> $past(pin_dir_q[1]) && $past(act_b_q) != 2'h0) // RULE12
    else $error("pin driven without direction bit");
  a_low_extreme: assert property (dual_w && ce_i && act_b_q == 2'h2 && cmp_b_q == 16'h0000
    |=> !wave_out_b_o) // RULE13
    else $error("BOTTOM compare not constant low");
  a_toggle_a: assert property (wgm_w == `DSFP_WGM_PFC_CMPA && act_a_q == 2'h1 && hit_a_w
    |=> wave_out_a_o != $past(wave_out_a_o)) // RULE14
    else $error("channel A did not toggle");

endmodule
`default_nettype wire

// ---- dsfp_pin_model.sv ----
// Port pin with an external load, driven by one timer channel.
// Assumes level and enable come registered on the timer clock.
`timescale 1ns/1ps
`default_nettype none

module dsfp_pin_model
(
  input wire logic clk_i,
  input wire logic out_i,
  input wire logic oe_i,
  output logic pin_o
);
  logic last_q;

  // Remember the last level that was really driven
  always_ff @(posedge clk_i)
  begin
    if (oe_i)
    begin
      last_q <= out_i;
    end
  end

  // Undriven pin drifts away from the last level
  assign pin_o = oe_i ? out_i : ~last_q;
endmodule

`default_nettype wire

// ---- dsfp_pwm_tb.sv ----
// Self-checking bench for the dual-slope PWM timer.
// Assumes the design files, the pin model and dsfp_cfg.svh.
`timescale 1ns/1ps
`default_nettype none
`include "dsfp_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module dsfp_pwm_tb;
  import dsfp_pkg::*;
  localparam int TOPV = 6;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic ce = 1'b1;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic [31:0] rdat;
  logic wb_ack_o;
  logic out_a, oe_a, ovr_a, out_b, oe_b, ovr_b, pin_a, pin_b, prev_b;
  logic rise_b;
  int n_fail = 0;
  int samples_checked = 0;
  int hits;

  // ----------------------------------------
  // Clock, design and pins
  // ----------------------------------------
  always #12.5 clk_i = ~clk_i;

  dsfp_pwm dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wave_out_a_o(out_a), .wave_oe_a_o(oe_a), .wave_ovr_a_o(ovr_a),
    .wave_out_b_o(out_b), .wave_oe_b_o(oe_b), .wave_ovr_b_o(ovr_b));
  dsfp_pin_model pin_a_u (.clk_i(clk_i), .out_i(out_a), .oe_i(oe_a), .pin_o(pin_a));
  dsfp_pin_model pin_b_u (.clk_i(clk_i), .out_i(out_b), .oe_i(oe_b), .pin_o(pin_b));

  // Rising edge of pin B as seen at a clock edge
  always @(posedge clk_i) prev_b <= pin_b;
  assign rise_b = (pin_b === 1'b1) && (prev_b === 1'b0);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'h3;
    wb_adr <= a;
    wb_dat <= d;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rdat = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (i == 20)
    begin
      n_fail++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000);
  endtask

  // High cycles of one pin over a window
  task automatic cnt_hi(input int n, input bit ch);
    hits = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      hits += ((ch ? pin_a : pin_b) === 1'b1);
    end
  endtask

  // Cycles between two rises of pin B, zero if none comes
  task automatic gap_of(input int b, output int g);
    int i;
    g = 0;
    for (i = 0; i < b && !rise_b; i++) @(posedge clk_i);
    if (i == b) return;
    @(posedge clk_i);
    for (g = 1; g < b && !rise_b; g++) @(posedge clk_i);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`DSFP_OFS_WAVE_CTRL);
    `CHK("wave_ctrl reset", 32'h0000_0000, rdat);
    rd(`DSFP_OFS_FLAGS);
    `CHK("flags reset", 32'h0000_0000, rdat);
    rd(8'h20);
    `CHK("unmapped", 32'h0000_0000, rdat);
    wr(`DSFP_OFS_WAVE_CTRL, 32'h0000_00FF);
    rd(`DSFP_OFS_WAVE_CTRL);
    `CHK("wave_ctrl fields", 32'h0000_00F3, rdat);
    wr(`DSFP_OFS_WAVE_CTRL, 32'h0000_0000);
  endtask

  task automatic t_pins;
    for (int a = 0; a < 4; a++)
      for (int d = 0; d < 4; d++)
      begin
        wr(`DSFP_OFS_WAVE_CTRL, {24'h0, a[1:0], a[1:0], 4'h0});
        wr(`DSFP_OFS_PIN_DIR, d);
        repeat (3) @(posedge clk_i);
        `CHK("ovr_a", a != 0, ovr_a);
        `CHK("ovr_b", a != 0, ovr_b);
        `CHK("oe_a", (a != 0) && d[0], oe_a);
        `CHK("oe_b", (a != 0) && d[1], oe_b);
      end
  endtask

  task automatic t_pwm;
    int c;
    int act;
    wr(`DSFP_OFS_CMP_A, TOPV);
    wr(`DSFP_OFS_CTRL_B, 32'h0000_0011);
    wr(`DSFP_OFS_PIN_DIR, 32'h0000_0003);
    for (int i = 0; i < 6; i++)
    begin
      act = (i < 3) ? 2 : 3;
      c = (i % 3 == 0) ? 0 : (i % 3 == 1) ? 2 : TOPV;
      wr(`DSFP_OFS_CMP_B, c);
      wr(`DSFP_OFS_WAVE_CTRL, {24'h0, 2'b00, act[1:0], 4'h1});
      repeat (6 * TOPV) @(posedge clk_i);
      cnt_hi(2 * TOPV, 1'b0);
      `CHK("duty b", (act == 2) ? 2 * c : 2 * TOPV - 2 * c, hits);
    end
  endtask

  task automatic t_toggle;
    wr(`DSFP_OFS_WAVE_CTRL, 32'h0000_0041);
    repeat (6 * TOPV) @(posedge clk_i);
    cnt_hi(4 * TOPV, 1'b1);
    `CHK("toggle a", 2 * TOPV, hits);
    // Clock enable low freezes the output level
    ce <= 1'b0;
    cnt_hi(4 * TOPV, 1'b1);
    ce <= 1'b1;
    `CHK("ce freeze", 1'b1, (hits == 0 || hits == 4 * TOPV));
  endtask

  task automatic t_flags;
    wr(`DSFP_OFS_FLAGS, 32'h0000_000F);
    repeat (3 * TOPV) @(posedge clk_i);
    rd(`DSFP_OFS_FLAGS);
    `CHK("flags mode 9", 4'h7, rdat[3:0]);
    wr(`DSFP_OFS_CAP_TOP, TOPV);
    wr(`DSFP_OFS_WAVE_CTRL, 32'h0000_0020);
    wr(`DSFP_OFS_CMP_A, TOPV + 4);
    wr(`DSFP_OFS_CMP_B, 2);
    repeat (6 * TOPV) @(posedge clk_i);
    wr(`DSFP_OFS_FLAGS, 32'h0000_000F);
    repeat (3 * TOPV) @(posedge clk_i);
    rd(`DSFP_OFS_FLAGS);
    `CHK("flags mode 8", 4'hD, rdat[3:0]);
    cnt_hi(2 * TOPV, 1'b0);
    `CHK("duty mode 8", 4, hits);
    wr(`DSFP_OFS_CMP_A, 3);
    wr(`DSFP_OFS_WAVE_CTRL, 32'h0000_00A0);
    repeat (6 * TOPV) @(posedge clk_i);
    cnt_hi(2 * TOPV, 1'b1);
    `CHK("duty a mode 8", 6, hits);
    wr(`DSFP_OFS_CMP_A, TOPV + 4);
  endtask

  task automatic t_ctc;
    wr(`DSFP_OFS_CTRL_B, 32'h0000_0009);
    wr(`DSFP_OFS_CMP_A, 20);
    wr(`DSFP_OFS_CMP_B, 5);
    wr(`DSFP_OFS_WAVE_CTRL, 32'h0000_0030);
    repeat (30) @(posedge clk_i);
    `CHK("ctc high", 1'b1, pin_b);
    wr(`DSFP_OFS_WAVE_CTRL, 32'h0000_0020);
    repeat (30) @(posedge clk_i);
    `CHK("ctc low", 1'b0, pin_b);
    wr(`DSFP_OFS_WAVE_CTRL, 32'h0000_0010);
    repeat (25) @(posedge clk_i);
    hits = 0;
    repeat (84)
    begin
      @(posedge clk_i);
      hits += rise_b;
    end
    `CHK("ctc toggle", 2, hits);
  endtask

  task automatic t_period;
    int g;
    int n;
    wr(`DSFP_OFS_CTRL_B, 32'h0000_0010);
    wr(`DSFP_OFS_COUNT, 32'h0000_0000);
    wr(`DSFP_OFS_CMP_B, 1);
    wr(`DSFP_OFS_WAVE_CTRL, 32'h0000_0021);
    wr(`DSFP_OFS_CTRL_B, 32'h0000_0011);
    wr(`DSFP_OFS_CMP_A, 3);
    for (int cs = 1; cs < 7; cs++)
    begin
      n = (cs == 1) ? 1 : (cs == 2) ? 8 : (cs == 3) ? 64 : (cs == 4) ? 256 : 1024;
      wr(`DSFP_OFS_CTRL_B, 8'h10 | cs);
      repeat (n + 44) @(posedge clk_i);
      gap_of((cs == 6) ? 500 : 14 * n + 50, g);
      `CHK("period", (cs == 6) ? 0 : 6 * n, g);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_pins();
    t_pwm();
    t_toggle();
    t_flags();
    t_ctc();
    t_period();
    final_report();
  end
endmodule

`default_nettype wire
